//--- pkg/sar_defs.svh
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// register byte offsets
`define SAR_OFF_SC 8'h00
`define SAR_OFF_RH 8'h04
`define SAR_OFF_RL 8'h08
`define SAR_OFF_CLK 8'h0C
`define SAR_OFF_PDATA 8'h10
`define SAR_OFF_PDDR 8'h14
`define SAR_OFF_PIN 8'h18

// status and control fields
`define SAR_SC_CONV_COMPLETE_FLAG 7
`define SAR_SC_IEN 6
`define SAR_SC_CONT 5
`define SAR_SC_CH_HI 4

// clock register fields
`define SAR_CLK_DIV_HI 7
`define SAR_CLK_DIV_LO 5
`define SAR_CLK_ICLK 4
`define SAR_CLK_FMT_HI 3
`define SAR_CLK_FMT_LO 2

// reset values
`define SAR_RST_CH 5'h1F
`define SAR_RST_CLK 8'h00

// channel codes
`define SAR_CH_REFH 5'h1D
`define SAR_CH_REFL 5'h1E
`define SAR_CH_OFF 5'h1F

// conversion timing in converter clock ticks
`define SAR_MSB_STEP 5'h06
`define SAR_LAST_STEP 5'h0F
`define SAR_DONE_STEP 5'h10

// result codes
`define SAR_FULL 10'h3FF
`define SAR_ZERO 10'h000
`define SAR_TRIAL 10'h200

`endif

//--- pkg/sar_pkg.sv
package sar_pkg;
  typedef enum logic [1:0] {
    SAR_FMT_LEFT,
    SAR_FMT_RIGHT,
    SAR_FMT_LSIGNED,
    SAR_FMT_TRUNC8
  } sar_fmt_e;

  typedef enum logic {
    SAR_ST_IDLE,
    SAR_ST_CONV
  } sar_state_e;
endpackage

//--- pkg/sar_clk_if.sv
`timescale 1ns/1ps
interface sar_clk_if;
  logic input_clock_select;
  logic [2:0] clock_prescale_field;
  logic conv_tick;
  modport ctrl (output input_clock_select, output clock_prescale_field, input conv_tick);
  modport gen (input input_clock_select, input clock_prescale_field, output conv_tick);
endinterface

//--- src/sar_prescaler.sv
`timescale 1ns/1ps
`include "sar_defs.svh"
module sar_prescaler (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // crystal-derived clock, sampled as a plain input
  input wire logic crystal_derived_clock,
  // settings and tick
  sar_clk_if.gen cif
);
  logic x1;
  logic x2;
  logic x3;
  logic x_level;
  logic [3:0] cnt;
  logic [3:0] last;
  logic in_tick;

  // crystal edges only count once two stages agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      x1 <= 1'b0;
      x2 <= 1'b0;
      x3 <= 1'b0;
      x_level <= 1'b0;
    end else begin
      x1 <= crystal_derived_clock;
      x2 <= x1;
      x3 <= x2;
      if (x2 == x3) begin
        x_level <= x3;
      end
    end
  end

  always_comb begin
    // source select, then divide
    in_tick = cif.input_clock_select ? 1'b1 : (x2 & x3 & ~x_level);
    // top bit set means divide by 16
    if (cif.clock_prescale_field[2]) begin
      last = 4'hF;
    end else begin
      last = 4'((5'h01 << cif.clock_prescale_field[1:0]) - 5'h01);
    end
  end

  // free running so a start lands anywhere in a period
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      cif.conv_tick <= 1'b0;
    end else begin
      cif.conv_tick <= 1'b0;
      if (in_tick) begin
        if (cnt >= last) begin
          cnt <= 4'h0;
          cif.conv_tick <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

  // back-to-back ticks only when the bus clock is divided by one
  a_div_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cif.conv_tick && (last != 4'h0 || !cif.input_clock_select) |=> !cif.conv_tick)
    else $error("converter tick spacing wrong");
endmodule

//--- src/sar_adc_sequencer.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "sar_defs.svh"
// Behaviour
// - one of ten channels muxed to converter
// - selected pin taken from port logic
// - port writes ignore the selected pin
// - port read of selected pin gives 0
// - full scale 3FF, bottom 000, linear
// - any status/control write starts conversion, except with the all-ones channel
// - conversion lasts 16 to 17 ticks
// - bus or crystal clock, then prescaled
// - partial first tick counts as seventeenth
// - continuous results overwrite unread ones
// - continuous mode restarts until bit cleared
// - complete flag set, cleared by data read
// - four result formats by two bits
// - left: eight msbs high, low after high
// - right: two msbs high, eight low
// - signed: left layout, msb inverted
// - truncated: eight msbs low, no interlock
// - interrupt per conversion, flag reads zero
// - runs in wait, interrupt wakes processor
// - five-bit channel, refs, all-ones off
// - prescale 1,2,4,8,16, top bit sixteen
// - interrupt cleared by data read/control write
// - high read freezes low until read
module sar_adc_sequencer #(
  parameter int NCH = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal-derived clock input
  input wire logic crystal_derived_clock,
  // shared port pins
  input wire logic [NCH-1:0] pin_in,
  output logic [NCH-1:0] pin_out,
  output logic [NCH-1:0] pin_oe,
  // analog front end
  output logic [4:0] ana_channel,
  output logic ana_power_off,
  output logic ana_sample,
  output logic [9:0] dac_code,
  input wire logic comp_in,
  // interrupt request, also the wait-mode wake
  output logic conv_irq
);
  import sar_pkg::*;
  sar_clk_if cif ();
  sar_prescaler u_pre (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .crystal_derived_clock(crystal_derived_clock),
    .cif(cif)
  );
  localparam logic [7:0] RST_CLK = `SAR_RST_CLK;
  sar_state_e st;
  sar_fmt_e fmt;
  logic [4:0] step;
  logic [9:0] sar, raw;
  logic [3:0] bidx;
  logic cont, irq_en, conv_complete_flag, lock;
  logic [7:0] res_hi, res_lo;
  logic [2:0] div;
  logic iclk;
  logic [NCH-1:0] pdata, pddr, pin_val, sel_mask, port_rd;
  logic acc, wr_sc, rd_hi, rd_lo, hi_pend, conv_done, store;
  logic [31:0] next_prdata;
  logic next_err;
  logic [4:0] tick_cnt;
  assign cif.input_clock_select = iclk;
  assign cif.clock_prescale_field = div;

  // apb decode; side effects land on the completing access cycle
  assign acc = psel & penable & pready;
  assign wr_sc = acc & pwrite & (paddr == `SAR_OFF_SC);
  assign rd_hi = acc & ~pwrite & (paddr == `SAR_OFF_RH);
  assign rd_lo = acc & ~pwrite & (paddr == `SAR_OFF_RL);

  // a start write in the finishing cycle aborts the result
  assign conv_done = (st == SAR_ST_CONV) & cif.conv_tick & (step == `SAR_DONE_STEP) & ~wr_sc;
  // a high read in flight holds off the store too, so high and low stay one result
  assign hi_pend = psel & ~pwrite & (paddr == `SAR_OFF_RH);
  // truncated mode has no interlock
  assign store = conv_done & (~(lock | hi_pend) | (fmt == SAR_FMT_TRUNC8));
  assign bidx = 4'(`SAR_LAST_STEP - step);

  // references give fixed codes; the array saturates outside them
  assign raw = (ana_channel == `SAR_CH_REFH) ? `SAR_FULL :
    ((ana_channel == `SAR_CH_REFL) ? `SAR_ZERO : sar);

  // pin synchronisers, channel decode and port masking, one bit each
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          pin_val[gi] <= 1'b0;
        end else begin
          s1 <= pin_in[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_val[gi] <= s3;
          end
        end
      end
      assign sel_mask[gi] = (ana_channel == 5'(gi));
      // a pin in use reads as zero
      assign port_rd[gi] = ~sel_mask[gi] & (pddr[gi] ? pdata[gi] : pin_val[gi]);
    end
  endgenerate

  // read mux, registered in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `SAR_OFF_SC: begin
        // flag reads zero while interrupts are on
        next_prdata[`SAR_SC_CONV_COMPLETE_FLAG] = conv_complete_flag & ~irq_en;
        next_prdata[`SAR_SC_IEN] = irq_en;
        next_prdata[`SAR_SC_CONT] = cont;
        next_prdata[`SAR_SC_CH_HI:0] = ana_channel;
      end
      `SAR_OFF_RH: next_prdata[7:0] = res_hi;
      `SAR_OFF_RL: next_prdata[7:0] = res_lo;
      `SAR_OFF_CLK: begin
        next_prdata[`SAR_CLK_DIV_HI:`SAR_CLK_DIV_LO] = div;
        next_prdata[`SAR_CLK_ICLK] = iclk;
        next_prdata[`SAR_CLK_FMT_HI:`SAR_CLK_FMT_LO] = fmt;
      end
      `SAR_OFF_PDATA: next_prdata[NCH-1:0] = pdata;
      `SAR_OFF_PDDR: next_prdata[NCH-1:0] = pddr;
      `SAR_OFF_PIN: next_prdata[NCH-1:0] = port_rd;
      default: next_err = 1'b1;
    endcase
  end

  // one wait-free access phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (psel & ~penable & ~pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ana_channel <= `SAR_RST_CH;
      cont <= 1'b0;
      irq_en <= 1'b0;
      div <= RST_CLK[`SAR_CLK_DIV_HI:`SAR_CLK_DIV_LO];
      iclk <= RST_CLK[`SAR_CLK_ICLK];
      fmt <= SAR_FMT_LEFT;
    end else if (acc & pwrite) begin
      if (paddr == `SAR_OFF_SC) begin
        // all ones powers the converter down
        ana_channel <= pwdata[`SAR_SC_CH_HI:0];
        cont <= pwdata[`SAR_SC_CONT];
        irq_en <= pwdata[`SAR_SC_IEN];
      end
      if (paddr == `SAR_OFF_CLK) begin
        div <= pwdata[`SAR_CLK_DIV_HI:`SAR_CLK_DIV_LO];
        iclk <= pwdata[`SAR_CLK_ICLK];
        // 00 left, 01 right, 10 signed, 11 truncated
        fmt <= sar_fmt_e'(pwdata[`SAR_CLK_FMT_HI:`SAR_CLK_FMT_LO]);
      end
    end
  end

  // port latches; the selected pin keeps its old bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pdata <= '0;
      pddr <= '0;
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      if (acc & pwrite & (paddr == `SAR_OFF_PDATA)) begin
        pdata <= (pwdata[NCH-1:0] & ~sel_mask) | (pdata & sel_mask);
      end
      if (acc & pwrite & (paddr == `SAR_OFF_PDDR)) begin
        pddr <= (pwdata[NCH-1:0] & ~sel_mask) | (pddr & sel_mask);
      end
      pin_out <= pdata;
      // converter owns the selected pin as an input
      pin_oe <= pddr & ~sel_mask;
    end
  end

  // sequencer; a control write restarts, or goes idle on the all-ones channel
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= SAR_ST_IDLE;
      step <= 5'h00;
      sar <= `SAR_ZERO;
    end else if (wr_sc) begin
      step <= 5'h00;
      sar <= `SAR_ZERO;
      if (pwdata[`SAR_SC_CH_HI:0] == `SAR_CH_OFF) begin
        st <= SAR_ST_IDLE;
      end else begin
        st <= SAR_ST_CONV;
      end
    end else if ((st == SAR_ST_CONV) & cif.conv_tick) begin
      // first tick ends the partial cycle
      step <= step + 5'h01;
      if (step == `SAR_MSB_STEP - 5'h01) begin
        sar <= `SAR_TRIAL;
      end else if ((step >= `SAR_MSB_STEP) & (step <= `SAR_LAST_STEP)) begin
        if (!comp_in) begin
          sar[bidx] <= 1'b0;
        end
        if (bidx != 4'h0) begin
          sar[bidx - 4'h1] <= 1'b1;
        end
      end
      if (step == `SAR_DONE_STEP) begin
        step <= 5'h00;
        // continuous mode goes straight on
        st <= cont ? SAR_ST_CONV : SAR_ST_IDLE;
        sar <= `SAR_ZERO;
      end
    end
  end

  // result registers and interlock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      res_hi <= 8'h00;
      res_lo <= 8'h00;
      lock <= 1'b0;
    end else begin
      if (rd_lo) begin
        lock <= 1'b0;
      end
      if (rd_hi & (fmt != SAR_FMT_TRUNC8)) begin
        lock <= 1'b1;
      end
      // unread results are simply overwritten
      if (store) begin
        unique case (fmt)
          SAR_FMT_LEFT: begin
            res_hi <= raw[9:2];
            res_lo <= {raw[1:0], 6'h00};
          end
          SAR_FMT_RIGHT: begin
            res_hi <= {6'h00, raw[9:8]};
            res_lo <= raw[7:0];
          end
          SAR_FMT_LSIGNED: begin
            res_hi <= {~raw[9], raw[8:2]};
            res_lo <= {raw[1:0], 6'h00};
          end
          SAR_FMT_TRUNC8: begin
            res_hi <= 8'h00;
            res_lo <= raw[9:2];
          end
        endcase
      end
    end
  end

  // flag and interrupt; a completion beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      conv_complete_flag <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      if (rd_hi | rd_lo) begin
        conv_complete_flag <= 1'b0;
      end
      if (rd_hi | rd_lo | wr_sc) begin
        conv_irq <= 1'b0;
      end
      if (conv_done & ~irq_en) begin
        conv_complete_flag <= 1'b1;
      end
      // no gating on wait, so the request can wake the core
      if (conv_done & irq_en) begin
        conv_irq <= 1'b1;
      end
    end
  end

  // analog controls
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ana_power_off <= 1'b1;
      ana_sample <= 1'b0;
    end else begin
      ana_power_off <= (ana_channel == `SAR_CH_OFF);
      ana_sample <= (st == SAR_ST_CONV) & (step < `SAR_MSB_STEP);
    end
  end
  assign dac_code = sar; // comparator judges the trial now on the array

  // helper: ticks seen since the conversion began
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wr_sc || conv_done) begin
      tick_cnt <= 5'h00;
    end else if ((st == SAR_ST_CONV) & cif.conv_tick) begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_conv_length: assert property (conv_done |-> tick_cnt == 5'h10)
    else $error("conversion length wrong");
  a_start_write: assert property (wr_sc && pwdata[4:0] != `SAR_CH_OFF
    |=> st == SAR_ST_CONV && step == 5'h00)
    else $error("control write did not start conversion");
  a_cont_restart: assert property (conv_done && cont |=> st == SAR_ST_CONV && step == 5'h00)
    else $error("continuous mode did not restart");
  a_flag_set: assert property (conv_done && !irq_en |=> conv_complete_flag)
    else $error("complete flag not set");
  a_irq_raise: assert property (conv_done && irq_en |=> conv_irq && !$rose(conv_complete_flag))
    else $error("interrupt not raised");
  a_irq_clear: assert property (conv_irq && (rd_hi || wr_sc) && !conv_done |=> !conv_irq)
    else $error("interrupt not cleared");
  a_low_frozen: assert property (lock && !rd_lo && fmt != SAR_FMT_TRUNC8 |=> $stable(res_lo))
    else $error("low result changed while frozen");
  a_trunc_layout: assert property (store && fmt == SAR_FMT_TRUNC8
    |=> res_hi == 8'h00 && res_lo == $past(raw[9:2]))
    else $error("truncated layout wrong");
  a_right_layout: assert property (store && fmt == SAR_FMT_RIGHT
    |=> res_hi[7:2] == 6'h00 && res_lo == $past(raw[7:0]))
    else $error("right layout wrong");
  a_pin_owned: assert property ($stable(sel_mask) |-> (pin_oe & sel_mask) == '0)
    else $error("selected pin still driven");
  a_port_guard: assert property (acc && pwrite && paddr == `SAR_OFF_PDATA
    |=> (pdata & sel_mask) == $past(pdata & sel_mask))
    else $error("port write reached selected pin");

  c_cont_done: cover property (conv_done && cont ##[1:400] conv_done);
  c_lost_result: cover property (lock && conv_done);
  c_irq_wake: cover property (conv_irq ##1 rd_hi);
endmodule

//--- test/sar_afe_model.sv
`timescale 1ns/1ps
module sar_afe_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // converter side
  input wire logic [4:0] ana_channel,
  input wire logic ana_power_off,
  input wire logic [9:0] dac_code,
  output logic comp_in,
  // ten-bit level per channel
  input wire logic [99:0] levels
);
  logic junk;
  int idx;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
    end
  end
  // an unpowered or unmapped input gives a toggling answer, never a steady level
  always_comb begin
    idx = int'(ana_channel);
    if (ana_power_off || idx > 9) begin
      comp_in = junk;
    end else begin
      comp_in = (dac_code <= levels[idx*10 +: 10]);
    end
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "sar_defs.svh"
module tb_top;
  import sar_pkg::*;
  localparam int LIMIT = 20000;
  logic sys_clk, rst_n, psel, penable, pwrite, crystal_derived_clock;
  logic pready, pslverr, ana_power_off, ana_sample, comp_in, conv_irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, hi;
  logic [9:0] pin_in, pin_out, pin_oe, dac_code;
  logic [4:0] ana_channel;
  logic [99:0] levels;
  int fails, tests_run, cyc, n;
  sar_fmt_e f;
  logic [4:0] chs [6] = '{5'h03, 5'h05, 5'h00, 5'h09, `SAR_CH_REFH, `SAR_CH_REFL};
  logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int dv [6] = '{1, 2, 4, 8, 16, 16};

  sar_adc_sequencer #(.NCH(10)) i_sar_adc_sequencer (.sys_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .crystal_derived_clock, .pin_in,
    .pin_out, .pin_oe, .ana_channel, .ana_power_off, .ana_sample, .dac_code, .comp_in,
    .conv_irq);
  sar_afe_model i_sar_afe_model (.sys_clk, .rst_n, .ana_channel, .ana_power_off,
    .dac_code, .comp_in, .levels);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // crystal clock rises every 8 bus cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    crystal_derived_clock <= cyc[2];
    if (cyc == LIMIT) begin
      fails++;
      close_out;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // caller stands just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_flag;
    int k;
    k = 0;
    do begin
      rd(`SAR_OFF_SC);
      k++;
    end while (r[7] !== 1'b1 && k < 100);
    chk("flag_wait", k < 100, 1);
  endtask

  task automatic wait_irq;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (conv_irq !== 1'b1 && n < 2000);
    @(posedge sys_clk);
  endtask

  task automatic rd_res;
    rd(`SAR_OFF_RH);
    hi = r;
    rd(`SAR_OFF_RL);
  endtask

  function automatic logic [15:0] fmt_exp(input logic [1:0] m, input logic [9:0] v);
    case (m)
      2'h0: fmt_exp = {v[9:2], v[1:0], 6'h00};
      2'h1: fmt_exp = {6'h00, v[9:8], v[7:0]};
      2'h2: fmt_exp = {~v[9], v[8:2], v[1:0], 6'h00};
      default: fmt_exp = {8'h00, v[9:2]};
    endcase
  endfunction

  function automatic logic [9:0] exp_res(input logic [4:0] ch);
    if (ch == `SAR_CH_REFH) return `SAR_FULL;
    if (ch == `SAR_CH_REFL) return `SAR_ZERO;
    return levels[int'(ch)*10 +: 10];
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata, cyc, fails, tests_run} = '0;
    pin_in = 10'h2C7;
    levels = '0;
    levels[30 +: 10] = 10'h2D6;
    levels[50 +: 10] = 10'h3FF;
    levels[90 +: 10] = 10'h155;
    rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`SAR_OFF_SC);
    chk("sc_reset", r, 32'h1F);
    rd(`SAR_OFF_CLK);
    chk("clk_reset", r, 32'h0);
    rd(8'h40);
    chk("unmapped", {r[30:0], err}, 32'h1);
    // every format, boundary levels and both references
    for (int k = 0; k < 6; k++) begin
      f = sar_fmt_e'(k % 4);
      wr(`SAR_OFF_CLK, {24'h0, 4'h1, f, 2'h0});
      wr(`SAR_OFF_SC, {27'h0, chs[k]});
      wait_flag;
      rd_res;
      chk("result", {hi[7:0], r[7:0]}, fmt_exp(f, exp_res(chs[k])));
      rd(`SAR_OFF_SC);
      chk("flag_clear", r, {27'h0, chs[k]});
    end
    // conversion length for every prescale, interrupt mode
    for (int k = 0; k < 6; k++) begin
      wr(`SAR_OFF_CLK, {24'h0, divs[k], 5'h10});
      wr(`SAR_OFF_SC, 32'h43);
      wait_irq;
      chk("conv_len", n >= 16 * dv[k] - 1 && n <= 17 * dv[k] + 3, 1);
      rd(`SAR_OFF_SC);
      chk("flag_ien", r, 32'h43);
      rd(`SAR_OFF_RH);
      @(negedge sys_clk);
      chk("irq_rd_clr", conv_irq, 0);
      @(posedge sys_clk);
    end
    // crystal source, period 8 bus cycles
    wr(`SAR_OFF_CLK, 32'h0);
    wr(`SAR_OFF_SC, 32'h43);
    wait_irq;
    chk("xtal_len", n >= 127 && n <= 148, 1);
    wr(`SAR_OFF_SC, 32'h1F);
    @(negedge sys_clk);
    chk("irq_wr_clr", {conv_irq, ana_power_off}, 2'b01);
    @(posedge sys_clk);
    rd(`SAR_OFF_RL);
    // left interlock: high read freezes low
    wr(`SAR_OFF_CLK, 32'h10);
    wr(`SAR_OFF_SC, 32'h03);
    wait_flag;
    rd(`SAR_OFF_RH);
    chk("left_hi", r, 32'hB5);
    levels[30 +: 10] <= 10'h0C1;
    wr(`SAR_OFF_SC, 32'h03);
    wait_flag;
    rd(`SAR_OFF_RL);
    chk("frozen_lo", r, 32'h80);
    wr(`SAR_OFF_SC, 32'h03);
    wait_flag;
    rd_res;
    chk("unfrozen", {hi[7:0], r[7:0]}, fmt_exp(2'h0, 10'h0C1));
    // truncated mode has no interlock
    wr(`SAR_OFF_CLK, 32'h1C);
    wr(`SAR_OFF_SC, 32'h03);
    wait_flag;
    rd(`SAR_OFF_RH);
    levels[30 +: 10] <= 10'h3A4;
    wr(`SAR_OFF_SC, 32'h03);
    wait_flag;
    rd(`SAR_OFF_RL);
    chk("trunc_lo", r, 32'hE9);
    // continuous mode, right justified
    wr(`SAR_OFF_CLK, 32'h14);
    wr(`SAR_OFF_SC, 32'h25);
    wait_flag;
    rd_res;
    chk("cont_first", {hi[7:0], r[7:0]}, 16'h03FF);
    levels[50 +: 10] <= 10'h2A5;
    repeat (60) @(posedge sys_clk);
    rd_res;
    chk("cont_over", {hi[7:0], r[7:0]}, 16'h02A5);
    levels[50 +: 10] <= 10'h0F0;
    repeat (40) @(posedge sys_clk);
    rd_res;
    chk("cont_next", {hi[7:0], r[7:0]}, 16'h00F0);
    // the conversion in flight at this write is aborted by the sequencer
    wr(`SAR_OFF_SC, 32'h05);
    repeat (40) @(posedge sys_clk);
    rd(`SAR_OFF_SC);
    chk("single_done", r, 32'h85);
    rd(`SAR_OFF_RH);
    repeat (40) @(posedge sys_clk);
    rd(`SAR_OFF_SC);
    chk("cont_stop", r, 32'h05);
    // shared pins, converter off while the port is set up
    wr(`SAR_OFF_SC, 32'h1F);
    wr(`SAR_OFF_PDDR, 32'h3FF);
    wr(`SAR_OFF_PDATA, 32'h155);
    wr(`SAR_OFF_SC, 32'h02);
    @(negedge sys_clk);
    chk("oe_sel", pin_oe, 10'h3FB);
    @(posedge sys_clk);
    rd(`SAR_OFF_PIN);
    chk("pin_rd", r, 32'h151);
    wr(`SAR_OFF_PDATA, 32'h2AA);
    @(negedge sys_clk);
    chk("out_kept", pin_out, 10'h2AE);
    @(posedge sys_clk);
    wr(`SAR_OFF_PDDR, 32'h0);
    rd(`SAR_OFF_PIN);
    chk("pin_in_rd", r, 32'h2C3);
    wr(`SAR_OFF_SC, 32'h1F);
    @(negedge sys_clk);
    chk("ddr_kept", pin_oe, 10'h004);
    close_out;
  end
endmodule
